// [src/fpmc_params.svh]
/*
 * Constants of the front panel menu controller: timing figures, register
 * offsets, setting limits and reset values of the stored settings.
 * Assumes a single 250 MHz clock and a 32-bit register bus with byte addresses.
 */
`ifndef FPMC_PARAMS_SVH
`define FPMC_PARAMS_SVH

// Clock rate and timing figures, times in milliseconds.
`define FPMC_CLK_KHZ 250000
`define FPMC_IDLE_MS 12000
`define FPMC_LAMP_MS 1000
`define FPMC_VER_MS 1000
`define FPMC_DEB_MS 10

// Register byte offsets.
`define FPMC_OFS_STATUS 4'h0
`define FPMC_OFS_NV_FREQ 4'h4
`define FPMC_OFS_NV_LEVEL 4'h8
`define FPMC_OFS_NV_MISC 4'hC

// Setting limits, 13-bit signed.
`define FPMC_UPF_LO 13'h03B6
`define FPMC_UPF_HI 13'h06D6
`define FPMC_DNF_LO 13'h07D0
`define FPMC_DNF_HI 13'h0A8C
`define FPMC_LVL_LO 13'h1FD8
`define FPMC_LVL_HI 13'h1FF6
`define FPMC_UPG_LO 13'h1FF6
`define FPMC_UPG_HI 13'h001E
`define FPMC_DNG_LO 13'h0000
`define FPMC_DNG_HI 13'h0032
`define FPMC_ADR_LO 13'h0000
`define FPMC_ADR_HI 13'h00FF

// Cursor position of the return marker.
`define FPMC_CUR_RET 3'h7

// Reset values of the stored settings.
`define FPMC_RST_UPF 12'h6BD
`define FPMC_RST_DNF 12'hA73
`define FPMC_RST_LVL 8'hEC
`define FPMC_RST_UPG 8'h0A
`define FPMC_RST_DNG 8'h19

`endif

// [src/fpmc_pkg.sv]
/*
 * Types of the front panel menu controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpmc_pkg;

	typedef enum logic [3:0] {
		M_UPF, M_UPLVL, M_UPG, M_DNF, M_DNG, M_MUTE,
		M_REMOTE, M_SPEC, M_EXTREF, M_RSMODE, M_RSADDR, M_TEMP
	} fpmc_menu_t;

	typedef enum logic [2:0] {
		ST_LAMP, ST_VER, ST_NORMAL, ST_EDIT, ST_SAVEQ
	} fpmc_state_t;

	typedef struct packed {
		logic menu;
		logic left;
		logic right;
		logic up;
		logic down;
	} fpmc_sw_t;

	typedef struct packed {
		logic [11:0] upf;
		logic [11:0] dnf;
		logic [7:0] lvl;
		logic [7:0] upg;
		logic [7:0] dng;
		logic mute;
		logic remote;
		logic spec_inv;
		logic ext_ref;
		logic rs_mode;
		logic [7:0] rs_addr;
	} fpmc_set_t;

	typedef struct packed {
		fpmc_state_t phase;
		fpmc_menu_t menu;
		logic [2:0] cursor;
		logic [12:0] value;
		logic save_yes;
	} fpmc_disp_t;

endpackage

// [src/fpmc_top.sv]
/*
 * Front panel menu controller: three operator switches drive a fixed menu
 * walk that edits the converter settings, with save or discard at the end.
 * Assumes raw switch pins (high while actuated), PLL lock pins, and an
 * Avalon-MM master that restores stored settings after power returns.
 */
// Notes on behaviour
// - Twelve fixed menu items in order.
// - Edits kept only through confirmed session.
// - Twelve idle seconds abandon the session.
// - Saved settings kept and reapplied.
// - Power-up: lamp test, version, up frequency.
// - Horizontal switch moves cursor one place.
// - Vertical switch steps selected digit.
// - Vertical switch toggles on/off items.
// - Frequency applied only after save.
// - Level and gain apply at once.
// - Save menu after last item or marker.
// - Yes commits, no restores previous settings.
// - Confirm press advances to next item.
// - Input level -40 to -10, 1 dB.
// - Up gain limited -10 to +30.
// - Down gain 0 to 50, 1/10 dB.
// - Any PLL unlock raises the alarm.
`timescale 1ns/1ps
`default_nettype none
`include "fpmc_params.svh"

module fpmc_top #(
	parameter logic [31:0] IDLE_CYC = 32'(64'(`FPMC_IDLE_MS) * 64'(`FPMC_CLK_KHZ)),
	parameter logic [31:0] LAMP_CYC = 32'(64'(`FPMC_LAMP_MS) * 64'(`FPMC_CLK_KHZ)),
	parameter logic [31:0] VER_CYC = 32'(64'(`FPMC_VER_MS) * 64'(`FPMC_CLK_KHZ)),
	parameter logic [31:0] DEB_CYC = 32'(64'(`FPMC_DEB_MS) * 64'(`FPMC_CLK_KHZ)),
	parameter int NPLL = 2,
	// Version shown at power-up; the value is arbitrary.
	parameter logic [12:0] FW_VERSION = 13'h0001
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Operator switches and sensors
	input wire fpmc_pkg::fpmc_sw_t sw_in,
	input wire logic [NPLL-1:0] pll_lock_in,
	input wire logic [7:0] temp_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Converter settings, display and LEDs
	output fpmc_pkg::fpmc_set_t cfg_out,
	output fpmc_pkg::fpmc_disp_t disp_out,
	output logic alarm_led_out,
	output logic mute_led_out,
	output logic remote_led_out
);
	import fpmc_pkg::*;

	fpmc_state_t state_q;
	fpmc_menu_t menu_q;
	fpmc_set_t edit_q, saved_q;
	logic [2:0] cursor_q, max_pos;
	logic [4:0] sw_s1_q, sw_s2_q, sw_st_q, sw_prev_q, act;
	logic [NPLL-1:0] pll_s1_q, pll_s2_q;
	logic [7:0] temp_s1_q, temp_s2_q;
	logic [31:0] deb_cnt_q, idle_cnt_q, phase_cnt_q;
	logic save_yes_q, idle_hit, sess, tog, act_any;
	logic menu_act, left_act, right_act, vert_act, vert_up;
	logic bus_wr, bus_rd;
	logic signed [12:0] cur_v, lo, hi, step, sum, nxt;

	// Pins are synchronised; the second stage alone feeds the logic.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sw_s1_q <= 5'h00;
			sw_s2_q <= 5'h00;
			pll_s1_q <= '0;
			pll_s2_q <= '0;
			temp_s1_q <= 8'h00;
			temp_s2_q <= 8'h00;
		end else begin
			sw_s1_q <= sw_in;
			sw_s2_q <= sw_s1_q;
			pll_s1_q <= pll_lock_in;
			pll_s2_q <= pll_s1_q;
			temp_s1_q <= temp_in;
			temp_s2_q <= temp_s1_q;
		end
	end

	// One shared filter: the settle time restarts only when every switch matches its stable state again.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			deb_cnt_q <= 32'h0;
			sw_st_q <= 5'h00;
			sw_prev_q <= 5'h00;
		end else begin
			sw_prev_q <= sw_st_q;
			if (sw_s2_q == sw_st_q) begin
				deb_cnt_q <= 32'h0;
			end else if (deb_cnt_q >= DEB_CYC - 32'h1) begin
				deb_cnt_q <= 32'h0;
				sw_st_q <= sw_s2_q;
			end else begin
				deb_cnt_q <= deb_cnt_q + 32'h1;
			end
		end
	end

	assign act = sw_st_q & ~sw_prev_q;
	assign menu_act = act[4];
	assign left_act = act[3];
	assign right_act = act[2];
	assign vert_act = act[1] | act[0];
	assign vert_up = act[1];
	assign act_any = |act;
	assign sess = (state_q == ST_EDIT) || (state_q == ST_SAVEQ);
	assign idle_hit = sess && !act_any && (idle_cnt_q >= IDLE_CYC - 32'h1);
	assign bus_wr = avs_write && !avs_waitrequest;
	assign bus_rd = avs_read && avs_waitrequest;

	// value per item: limits, digit range and toggle flag.
	always_comb begin
		cur_v = 13'h0000;
		lo = 13'h0000;
		hi = 13'h0000;
		max_pos = 3'h0;
		tog = 1'b0;
		case (menu_q)
			M_UPF: begin
				cur_v = {1'b0, edit_q.upf};
				lo = `FPMC_UPF_LO;
				hi = `FPMC_UPF_HI;
				max_pos = 3'h3;
			end
			M_UPLVL: begin
				cur_v = {{5{edit_q.lvl[7]}}, edit_q.lvl};
				lo = `FPMC_LVL_LO;
				hi = `FPMC_LVL_HI;
			end
			M_UPG: begin
				cur_v = {{5{edit_q.upg[7]}}, edit_q.upg};
				lo = `FPMC_UPG_LO;
				hi = `FPMC_UPG_HI;
				max_pos = 3'h1;
			end
			M_DNF: begin
				cur_v = {1'b0, edit_q.dnf};
				lo = `FPMC_DNF_LO;
				hi = `FPMC_DNF_HI;
				max_pos = 3'h3;
			end
			M_DNG: begin
				cur_v = {{5{edit_q.dng[7]}}, edit_q.dng};
				lo = `FPMC_DNG_LO;
				hi = `FPMC_DNG_HI;
				max_pos = 3'h1;
			end
			M_RSADDR: begin
				cur_v = {5'h00, edit_q.rs_addr};
				lo = `FPMC_ADR_LO;
				hi = `FPMC_ADR_HI;
				max_pos = 3'h2;
			end
			M_TEMP: cur_v = {5'h00, temp_s2_q};
			M_MUTE: begin
				cur_v = {12'h000, edit_q.mute};
				tog = 1'b1;
			end
			M_REMOTE: begin
				cur_v = {12'h000, edit_q.remote};
				tog = 1'b1;
			end
			M_SPEC: begin
				cur_v = {12'h000, edit_q.spec_inv};
				tog = 1'b1;
			end
			M_EXTREF: begin
				cur_v = {12'h000, edit_q.ext_ref};
				tog = 1'b1;
			end
			M_RSMODE: begin
				cur_v = {12'h000, edit_q.rs_mode};
				tog = 1'b1;
			end
			default: cur_v = 13'h0000;
		endcase
	end

	always_comb begin
		case (cursor_q)
			3'h0: step = 13'h0001;
			3'h1: step = 13'h000A;
			3'h2: step = 13'h0064;
			3'h3: step = 13'h03E8;
			default: step = 13'h0000;
		endcase
		sum = vert_up ? cur_v + step : cur_v - step;
		if (sum > hi) begin
			nxt = hi;
		end else if (sum < lo) begin
			nxt = lo;
		end else begin
			nxt = sum;
		end
	end

	// Power-up phases, menu walk and save question.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= ST_LAMP;
			menu_q <= M_UPF;
			cursor_q <= 3'h0;
			save_yes_q <= 1'b0;
			phase_cnt_q <= 32'h0;
		end else begin
			case (state_q)
				ST_LAMP, ST_VER: begin
					if (phase_cnt_q >= (state_q == ST_LAMP ? LAMP_CYC : VER_CYC) - 32'h1) begin
						phase_cnt_q <= 32'h0;
						state_q <= (state_q == ST_LAMP) ? ST_VER : ST_NORMAL;
					end else begin
						phase_cnt_q <= phase_cnt_q + 32'h1;
					end
				end
				// session opens on a confirm press
				ST_NORMAL: begin
					if (menu_act) begin
						state_q <= ST_EDIT;
						menu_q <= M_UPF;
						cursor_q <= 3'h0;
					end
				end
				ST_EDIT: begin
					if (idle_hit) begin
						state_q <= ST_NORMAL;
					end else if (menu_act) begin
						cursor_q <= 3'h0;
						if (cursor_q == `FPMC_CUR_RET || menu_q == M_TEMP) begin
							state_q <= ST_SAVEQ;
							save_yes_q <= 1'b1;
						end else begin
							menu_q <= fpmc_menu_t'(menu_q + 4'h1);
						end
					end else if (left_act) begin
						if (cursor_q == `FPMC_CUR_RET) begin
							cursor_q <= 3'h0;
						end else if (cursor_q < max_pos) begin
							cursor_q <= cursor_q + 3'h1;
						end
					end else if (right_act) begin
						if (cursor_q == 3'h0) begin
							cursor_q <= `FPMC_CUR_RET;
						end else if (cursor_q != `FPMC_CUR_RET) begin
							cursor_q <= cursor_q - 3'h1;
						end
					end
				end
				ST_SAVEQ: begin
					if (idle_hit || menu_act) begin
						state_q <= ST_NORMAL;
					end else if (vert_act) begin
						save_yes_q <= !save_yes_q;
					end
				end
				default: state_q <= ST_NORMAL;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idle_cnt_q <= 32'h0;
		end else if (!sess || act_any) begin
			idle_cnt_q <= 32'h0;
		end else begin
			idle_cnt_q <= idle_cnt_q + 32'h1;
		end
	end

	// Working copy: edits, restores and loads from the bus.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			edit_q <= '{`FPMC_RST_UPF, `FPMC_RST_DNF, `FPMC_RST_LVL, `FPMC_RST_UPG,
				`FPMC_RST_DNG, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
		end else if (idle_hit || (state_q == ST_SAVEQ && menu_act && !save_yes_q)) begin
			edit_q <= saved_q;
		end else if (state_q == ST_EDIT && vert_act && !menu_act && cursor_q != `FPMC_CUR_RET) begin
			case (menu_q)
				M_UPF: edit_q.upf <= nxt[11:0];
				M_UPLVL: edit_q.lvl <= nxt[7:0];
				M_UPG: edit_q.upg <= nxt[7:0];
				M_DNF: edit_q.dnf <= nxt[11:0];
				M_DNG: edit_q.dng <= nxt[7:0];
				M_RSADDR: edit_q.rs_addr <= nxt[7:0];
				M_MUTE: edit_q.mute <= !edit_q.mute;
				M_REMOTE: edit_q.remote <= !edit_q.remote;
				M_SPEC: edit_q.spec_inv <= !edit_q.spec_inv;
				M_EXTREF: edit_q.ext_ref <= !edit_q.ext_ref;
				M_RSMODE: edit_q.rs_mode <= !edit_q.rs_mode;
				default: edit_q <= edit_q;
			endcase
		end else if (bus_wr && !sess) begin
			case (avs_address)
				`FPMC_OFS_NV_FREQ: {edit_q.dnf, edit_q.upf} <= {avs_writedata[27:16], avs_writedata[11:0]};
				`FPMC_OFS_NV_LEVEL: {edit_q.dng, edit_q.upg, edit_q.lvl} <= avs_writedata[23:0];
				`FPMC_OFS_NV_MISC: {edit_q.rs_mode, edit_q.ext_ref, edit_q.spec_inv, edit_q.remote,
					edit_q.mute, edit_q.rs_addr} <= avs_writedata[12:0];
				default: edit_q <= edit_q;
			endcase
		end
	end

	// stored settings, reloaded by software after power returns
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			saved_q <= '{`FPMC_RST_UPF, `FPMC_RST_DNF, `FPMC_RST_LVL, `FPMC_RST_UPG,
				`FPMC_RST_DNG, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
		end else if (state_q == ST_SAVEQ && menu_act && save_yes_q && !idle_hit) begin
			saved_q <= edit_q;
		end else if (bus_wr && !sess) begin
			case (avs_address)
				`FPMC_OFS_NV_FREQ: {saved_q.dnf, saved_q.upf} <= {avs_writedata[27:16], avs_writedata[11:0]};
				`FPMC_OFS_NV_LEVEL: {saved_q.dng, saved_q.upg, saved_q.lvl} <= avs_writedata[23:0];
				`FPMC_OFS_NV_MISC: {saved_q.rs_mode, saved_q.ext_ref, saved_q.spec_inv,
					saved_q.remote, saved_q.mute, saved_q.rs_addr} <= avs_writedata[12:0];
				default: saved_q <= saved_q;
			endcase
		end
	end

	// frequency from saved, level and gain live
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_out <= '0;
			mute_led_out <= 1'b0;
			remote_led_out <= 1'b0;
			alarm_led_out <= 1'b0;
			disp_out <= '0;
		end else begin
			cfg_out <= saved_q;
			cfg_out.lvl <= edit_q.lvl;
			cfg_out.upg <= edit_q.upg;
			cfg_out.dng <= edit_q.dng;
			mute_led_out <= saved_q.mute;
			remote_led_out <= saved_q.remote;
			alarm_led_out <= !(&pll_s2_q);
			disp_out.phase <= state_q;
			disp_out.menu <= menu_q;
			disp_out.cursor <= cursor_q;
			disp_out.value <= (state_q == ST_VER) ? FW_VERSION : cur_v;
			disp_out.save_yes <= save_yes_q;
		end
	end

	// Every access waits one cycle; reads of unmapped words return zero.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (bus_rd) begin
				case (avs_address)
					`FPMC_OFS_STATUS: avs_readdata <= {20'h0, alarm_led_out, state_q, menu_q, 1'b0,
						cursor_q};
					`FPMC_OFS_NV_FREQ: avs_readdata <= {4'h0, saved_q.dnf, 4'h0, saved_q.upf};
					`FPMC_OFS_NV_LEVEL: avs_readdata <= {8'h0, saved_q.dng, saved_q.upg, saved_q.lvl};
					`FPMC_OFS_NV_MISC: avs_readdata <= {19'h0, saved_q.rs_mode, saved_q.ext_ref,
						saved_q.spec_inv, saved_q.remote, saved_q.mute, saved_q.rs_addr};
					default: avs_readdata <= 32'h0;
				endcase
			end
		end
	end

	property p_idle_abort;
		@(posedge clk_in) disable iff (!resetn_in)
		idle_hit |=> state_q == ST_NORMAL && edit_q == $past(saved_q);
	endproperty
	a_idle_abort: assert property (p_idle_abort) else $error("idle session not abandoned");

	// Saved settings cannot move inside a session, so the applied frequency must hold still.
	property p_freq_hold;
		@(posedge clk_in) disable iff (!resetn_in)
		sess && $past(sess) |=> $stable(cfg_out.upf);
	endproperty
	a_freq_hold: assert property (p_freq_hold) else $error("frequency applied before save");

	property p_no_restore;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_SAVEQ && menu_act && !save_yes_q |=> edit_q == $past(saved_q) ##1
			cfg_out.lvl == $past(saved_q.lvl, 2);
	endproperty
	a_no_restore: assert property (p_no_restore) else $error("no answer did not restore");

	property p_alarm;
		@(posedge clk_in) disable iff (!resetn_in)
		!(&pll_s2_q) |=> alarm_led_out;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm missing on unlock");

	property p_lvl_range;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_EDIT && vert_act && menu_q == M_UPLVL && cursor_q == 3'h0 && !menu_act
			|=> $signed(edit_q.lvl) >= -8'sd40 && $signed(edit_q.lvl) <= -8'sd10;
	endproperty
	a_lvl_range: assert property (p_lvl_range) else $error("input level out of range");

	property p_dng_step;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_EDIT && act[1] && menu_q == M_DNG && cursor_q == 3'h1 && !menu_act
			&& edit_q.dng < 8'h28 |=> edit_q.dng == $past(edit_q.dng) + 8'h0A;
	endproperty
	a_dng_step: assert property (p_dng_step) else $error("down gain tens step wrong");

	property p_toggle;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_EDIT && vert_act && tog && cursor_q == 3'h0 && !menu_act
			|=> cur_v[0] != $past(cur_v[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("on/off item did not toggle");

	property p_cursor_right;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_EDIT && right_act && !menu_act && !idle_hit && cursor_q != 3'h0
			&& cursor_q != `FPMC_CUR_RET |=> cursor_q == $past(cursor_q) - 3'h1;
	endproperty
	a_cursor_right: assert property (p_cursor_right) else $error("cursor not moved right");

	property p_advance;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_EDIT && menu_act && !idle_hit && menu_q == M_UPF && cursor_q != `FPMC_CUR_RET
			|=> menu_q == M_UPLVL && state_q == ST_EDIT;
	endproperty
	a_advance: assert property (p_advance) else $error("confirm did not advance");

	property p_lamp_first;
		@(posedge clk_in) disable iff (!resetn_in)
		state_q == ST_LAMP |=> state_q == ST_LAMP || state_q == ST_VER;
	endproperty
	a_lamp_first: assert property (p_lamp_first) else $error("power-up phase skipped");

endmodule
`default_nettype wire

// [testbench/fpmc_operator.sv]
/*
 * Operator model for the front panel menu controller: one switch press at
 * a time, with contact chatter, a held actuation and a settled release.
 * Assumes the bench calls press from its main sequence on the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fpmc_operator #(
	parameter int HOLD = 12
) (
	// Clock
	input wire logic clk_in,
	// Switch pins, high while actuated
	output fpmc_pkg::fpmc_sw_t sw_out
);
	import fpmc_pkg::*;

	initial sw_out = '0;

	// A real contact chatters before it settles, so each press opens with a bounce.
	task automatic press(input fpmc_sw_t k);
		@(posedge clk_in);
		sw_out <= k;
		@(posedge clk_in);
		sw_out <= '0;
		@(posedge clk_in);
		sw_out <= k;
		repeat (HOLD) @(posedge clk_in);
		sw_out <= '0;
		repeat (HOLD) @(posedge clk_in);
	endtask

endmodule

`default_nettype wire

// [testbench/test_front_panel_menu_controller.sv]
/*
 * Self-checking bench of the front panel menu controller with shortened
 * timing parameters, an operator model on the switches and bus tasks.
 * Assumes the package and the design files are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module test_front_panel_menu_controller;
	import fpmc_pkg::*;

	localparam fpmc_sw_t K_MENU = 5'h10;
	localparam fpmc_sw_t K_LEFT = 5'h08;
	localparam fpmc_sw_t K_RIGHT = 5'h04;
	localparam fpmc_sw_t K_UP = 5'h02;
	localparam fpmc_sw_t K_DN = 5'h01;

	logic clk_in;
	logic resetn_in;
	fpmc_sw_t sw;
	logic [1:0] pll_lock_in;
	logic [7:0] temp_in;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	fpmc_set_t cfg_out;
	fpmc_disp_t disp_out;
	logic alarm_led_out;
	logic mute_led_out;
	logic remote_led_out;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	int i;
	int lv;
	logic [15:0] lf;
	logic [31:0] rd;
	logic [12:0] e;
	logic [1:0] v;

	fpmc_operator op_u (.clk_in(clk_in), .sw_out(sw));

	fpmc_top #(
		.IDLE_CYC(32'h0000_00C8),
		.LAMP_CYC(32'h0000_0014),
		.VER_CYC(32'h0000_0014),
		.DEB_CYC(32'h0000_0004),
		.FW_VERSION(13'h0123)
	) dut_u (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.sw_in(sw),
		.pll_lock_in(pll_lock_in),
		.temp_in(temp_in),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.cfg_out(cfg_out),
		.disp_out(disp_out),
		.alarm_led_out(alarm_led_out),
		.mute_led_out(mute_led_out),
		.remote_led_out(remote_led_out)
	);

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Numeric items saturate at their limits instead of wrapping.
	function automatic logic [12:0] step(input int x, input int d, input int lo, input int hi);
		int r;
		r = x + d;
		if (r < lo) r = lo;
		if (r > hi) r = hi;
		return 13'(r);
	endfunction

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (!ok) begin
			$display("CHECK FAILED %0t %s", $time, msg);
			num_errors++;
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
			output logic [31:0] d);
		@(posedge clk_in);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			$display("CHECK FAILED %0t timeout", $time);
			num_errors++;
			summarize();
		end
	end

	initial begin
		resetn_in = 1'b0;
		pll_lock_in = 2'h3;
		temp_in = 8'h19;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		lf = 16'h0055;
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		n = 0;
		while (disp_out.phase === ST_LAMP && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		chk(disp_out.phase === ST_VER && disp_out.value === 13'h0123, "version");
		chk(n >= 17 && n <= 24, "lamp test length");
		while (disp_out.phase === ST_VER && n < 200) begin
			@(posedge clk_in);
			n++;
		end
		chk(disp_out.phase === ST_NORMAL && cfg_out.upf === 12'h6BD, "normal");
		bus(1'b0, 4'h4, 32'h0, rd);
		chk(rd === 32'h0A73_06BD, "stored frequencies");
		bus(1'b1, 4'h8, 32'h0031_1DD9, rd);
		bus(1'b0, 4'h8, 32'h0, rd);
		chk(rd === 32'h0031_1DD9 && cfg_out.lvl === 8'hD9, "level restore");
		bus(1'b0, 4'h2, 32'h0, rd);
		chk(rd === 32'h0, "unmapped read");
		$display("test power_up done");

		op_u.press(K_MENU);
		chk(disp_out.phase === ST_EDIT && disp_out.menu === M_UPF, "session open");
		op_u.press(K_MENU);
		chk(disp_out.menu === M_UPLVL && disp_out.cursor === 3'h0, "next item");
		repeat (2) op_u.press(K_DN);
		e = step(-39, -2, -40, -10);
		chk(cfg_out.lvl === e[7:0], "level floor");
		op_u.press(K_MENU);
		repeat (2) op_u.press(K_UP);
		e = step(29, 2, -10, 30);
		chk(cfg_out.upg === e[7:0], "up gain ceiling");
		repeat (2) op_u.press(K_MENU);
		op_u.press(K_LEFT);
		chk(disp_out.menu === M_DNG && disp_out.cursor === 3'h1, "cursor left");
		op_u.press(K_UP);
		e = step(49, 10, 0, 50);
		chk(cfg_out.dng === e[7:0], "down gain ceiling");
		repeat (6) op_u.press(K_DN);
		e = step(50, -60, 0, 50);
		chk(cfg_out.dng === e[7:0], "down gain floor");
		op_u.press(K_UP);
		e = step(0, 10, 0, 50);
		chk(cfg_out.dng === e[7:0], "down gain tens step");
		repeat (2) op_u.press(K_RIGHT);
		chk(disp_out.cursor === 3'h7, "cursor right to marker");
		op_u.press(K_MENU);
		chk(disp_out.phase === ST_SAVEQ && disp_out.save_yes === 1'b1, "save menu");
		op_u.press(K_DN);
		chk(disp_out.save_yes === 1'b0, "answer no");
		op_u.press(K_MENU);
		chk(disp_out.phase === ST_NORMAL && cfg_out.lvl === 8'hD9 && cfg_out.upg === 8'h1D
			&& cfg_out.dng === 8'h31, "discard restores");
		$display("test discard done");

		lf = lfsr(lf);
		n = 1 + int'(lf % 16'h0003);
		op_u.press(K_MENU);
		op_u.press(K_UP);
		chk(cfg_out.upf === 12'h6BD && disp_out.value === 13'h06BE, "frequency deferred");
		op_u.press(K_MENU);
		repeat (n) op_u.press(K_UP);
		lv = -39 + n;
		e = step(-39, n, -40, -10);
		chk(cfg_out.lvl === e[7:0], "level applied at once");
		for (i = 2; i < 12; i++) begin
			op_u.press(K_MENU);
			chk(disp_out.menu === fpmc_menu_t'(i), "menu order");
			if (i == 5) op_u.press(K_DN);
			if (i == 6) op_u.press(K_UP);
			if (i == 11) chk(disp_out.value === {5'h00, temp_in}, "temperature view");
		end
		op_u.press(K_MENU);
		chk(disp_out.phase === ST_SAVEQ && disp_out.save_yes === 1'b1, "after last");
		op_u.press(K_MENU);
		chk(cfg_out.upf === 12'h6BE && cfg_out.lvl === e[7:0], "yes commits");
		chk(cfg_out.mute === 1'b1 && mute_led_out === 1'b1, "mute toggled");
		chk(cfg_out.remote === 1'b1 && remote_led_out === 1'b1, "remote toggled");
		bus(1'b0, 4'h4, 32'h0, rd);
		chk(rd === 32'h0A73_06BE, "saved frequency stored");
		$display("test save done");

		repeat (2) op_u.press(K_MENU);
		op_u.press(K_DN);
		e = step(lv, -1, -40, -10);
		chk(cfg_out.lvl === e[7:0], "live level");
		bus(1'b1, 4'h8, 32'h0000_0000, rd);
		repeat (150) @(posedge clk_in);
		chk(disp_out.phase === ST_EDIT, "timer still running");
		repeat (100) @(posedge clk_in);
		e = step(lv, 0, -40, -10);
		chk(disp_out.phase === ST_NORMAL && cfg_out.lvl === e[7:0], "idle abandon");
		$display("test idle done");

		for (i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			v = (i < 2) ? 2'(i + 2) : lf[1:0];
			pll_lock_in <= v;
			temp_in <= lf[9:2];
			repeat (6) @(posedge clk_in);
			chk(alarm_led_out === ~&v, "alarm follows lock");
		end
		$display("test alarm done");
		summarize();
	end

endmodule

`default_nettype wire
